// ==== lhr_pkg.sv ====
// constants, types and helpers for the lcd host register access block
// assumes a single 25 MHz clock domain; nothing here holds state
package lhr_pkg;

  // memory target codes chosen by the address-setting instructions
  typedef enum logic [1:0] {
    LHR_TGT_DISPLAY = 2'h0, // display text memory
    LHR_TGT_GLYPH = 2'h1, // user glyph memory
    LHR_TGT_ICON = 2'h2 // icon memory
  } lhr_target_t;

  // one-hot sequencer states
  typedef enum logic [3:0] {
    LHR_ST_IDLE = 4'h1, // ready, busy indicator low
    LHR_ST_WRITE = 4'h2, // data register goes into memory
    LHR_ST_FETCH = 4'h4, // memory read issued
    LHR_ST_LOAD = 4'h8 // fetched word lands in data register
  } lhr_state_t;

  localparam int unsigned LHR_DATA_W = 8; // host bus width
  localparam int unsigned LHR_AC_W = 7; // address counter width
  localparam int unsigned LHR_MEM_AW = 9; // {target, counter}
  localparam logic [7:0] LHR_DR_RESET = 8'h00; // data register after reset
  localparam logic [6:0] LHR_AC_RESET = 7'h00; // address counter after reset
  localparam logic LHR_DIR_RESET = 1'b1; // increment after reset
  localparam int unsigned LHR_BUSY_BIT = 7; // busy indicator position

  // instruction patterns
  localparam logic [0:0] LHR_DISP_SET_CODE = 1'h1; // bit 7
  localparam logic [1:0] LHR_GLYPH_SET_CODE = 2'h1; // bits 7:6
  localparam logic [2:0] LHR_ICON_SET_CODE = 3'h1; // bits 7:5
  localparam logic [5:0] LHR_MODE_CODE = 6'h01; // bits 7:2
  localparam int unsigned LHR_MODE_DIR_BIT = 1; // 1 = increment
  localparam int unsigned LHR_SUB_AW = 5; // glyph and icon address width

  // one step of the address counter, wrapping at the counter width
  function automatic logic [6:0] lhr_step(input logic [6:0] ac, input logic inc);
    lhr_step = inc ? 7'(ac + 7'h01) : 7'(ac - 7'h01);
  endfunction : lhr_step

endpackage : lhr_pkg

// ==== lhr_mem.sv ====
// small synchronous memory holding display, glyph and icon words
// assumes one write or one read per cycle; read data come from a register
`timescale 1ns/10ps
`default_nettype none
module lhr_mem #(
  parameter int unsigned ADDR_W = 9,
  parameter int unsigned DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data
);
  // refuse shapes the storage cannot serve
  initial begin
    if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1) begin
      $error("lhr_mem: unsupported shape");
    end
  end

  logic [DATA_W-1:0] store [2**ADDR_W]; // word storage, no reset

  // write port and registered read port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      store[addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= store[addr];
    end
  end
endmodule : lhr_mem
`default_nettype wire

// ==== lhr_host_port.sv ====
// host register port of the lcd controller: status, instruction, data
// assumes host strobes are synchronous to ref_clk, one cycle long
`timescale 1ns/10ps
`default_nettype none
module lhr_host_port #(
  parameter int unsigned MEM_AW = lhr_pkg::LHR_MEM_AW
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic access_strobe, // one-cycle access request
  input wire logic register_select, // 0 instruction/status, 1 data
  input wire logic read_write, // 1 read, 0 write
  input wire logic [7:0] data_bus_in, // host write data
  output logic [7:0] data_bus_out, // read data, registered
  output logic data_bus_oe_n, // low while driving the bus
  output logic busy_indicator // high while working
);
  // refuse memory shapes that cannot hold target and counter
  initial begin
    if (MEM_AW != 2 + lhr_pkg::LHR_AC_W) begin
      $error("lhr_host_port: MEM_AW must equal counter width plus 2");
    end
  end

  lhr_pkg::lhr_state_t state; // sequencer
  lhr_pkg::lhr_state_t next_state; // sequencer next
  lhr_pkg::lhr_target_t target; // selected memory
  logic [6:0] address_counter; // current memory address
  logic [7:0] data_register; // staging word
  logic step_inc; // 1 increment, 0 decrement
  logic [7:0] mem_rd_data; // memory read word

  // request decode
  wire idle = (state == lhr_pkg::LHR_ST_IDLE);
  wire take = access_strobe & idle; // accepted only when idle
  wire instr_wr = take & ~register_select & ~read_write;
  wire data_wr = take & register_select & ~read_write;
  wire data_rd = take & register_select & read_write;
  wire status_rd = access_strobe & ~register_select & read_write;

  // instruction decode
  wire is_disp_set = (data_bus_in[7] == lhr_pkg::LHR_DISP_SET_CODE);
  wire is_glyph_set = (data_bus_in[7:6] == lhr_pkg::LHR_GLYPH_SET_CODE);
  wire is_icon_set = (data_bus_in[7:5] == lhr_pkg::LHR_ICON_SET_CODE);
  wire is_mode = (data_bus_in[7:2] == lhr_pkg::LHR_MODE_CODE);
  wire addr_set = instr_wr & (is_disp_set | is_glyph_set | is_icon_set);

  // memory port control
  wire mem_we = (state == lhr_pkg::LHR_ST_WRITE);
  wire mem_re = (state == lhr_pkg::LHR_ST_FETCH);
  wire [MEM_AW-1:0] mem_addr = {target, address_counter};
  wire [6:0] ac_stepped = lhr_pkg::lhr_step(address_counter, step_inc);

  // busy while any internal operation runs
  assign busy_indicator = ~idle;

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      lhr_pkg::LHR_ST_IDLE: begin
        if (data_wr) begin
          next_state = lhr_pkg::LHR_ST_WRITE;
        end else if (data_rd || addr_set) begin
          next_state = lhr_pkg::LHR_ST_FETCH;
        end
      end
      lhr_pkg::LHR_ST_WRITE: next_state = lhr_pkg::LHR_ST_IDLE;
      lhr_pkg::LHR_ST_FETCH: next_state = lhr_pkg::LHR_ST_LOAD;
      lhr_pkg::LHR_ST_LOAD: next_state = lhr_pkg::LHR_ST_IDLE;
      default: next_state = lhr_pkg::LHR_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= lhr_pkg::LHR_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // address counter, target and direction
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      address_counter <= lhr_pkg::LHR_AC_RESET;
      target <= lhr_pkg::LHR_TGT_DISPLAY;
      step_inc <= lhr_pkg::LHR_DIR_RESET;
    end else if (addr_set) begin
      // full 7-bit address for display, 5 bits for glyph and icon
      if (is_disp_set) begin
        address_counter <= data_bus_in[6:0];
        target <= lhr_pkg::LHR_TGT_DISPLAY;
      end else if (is_glyph_set) begin
        address_counter <= {2'h0, data_bus_in[4:0]};
        target <= lhr_pkg::LHR_TGT_GLYPH;
      end else begin
        address_counter <= {2'h0, data_bus_in[4:0]};
        target <= lhr_pkg::LHR_TGT_ICON;
      end
    end else if (instr_wr && is_mode) begin
      step_inc <= data_bus_in[lhr_pkg::LHR_MODE_DIR_BIT];
    end else if (mem_we || data_rd) begin
      address_counter <= ac_stepped;
    end
  end

  // data register: host write, or fetched word
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_register <= lhr_pkg::LHR_DR_RESET;
    end else if (data_wr) begin
      data_register <= data_bus_in;
    end else if (state == lhr_pkg::LHR_ST_LOAD) begin
      data_register <= mem_rd_data;
    end
  end

  // read bus: status or data; the instruction register has no path out
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_bus_out <= 8'h00;
      data_bus_oe_n <= 1'b1;
    end else begin
      data_bus_oe_n <= ~(status_rd | data_rd);
      if (status_rd) begin
        data_bus_out <= {busy_indicator, address_counter};
      end else if (data_rd) begin
        data_bus_out <= data_register;
      end
    end
  end

  // backing memory for all three targets
  lhr_mem #(
    .ADDR_W(MEM_AW),
    .DATA_W(lhr_pkg::LHR_DATA_W)
  ) u_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_we),
    .rd_en(mem_re),
    .addr(mem_addr),
    .wr_data(data_register),
    .rd_data(mem_rd_data)
  );

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_BUSY_IGNORES: assert property (
    access_strobe && busy_indicator && !register_select && !read_write
    |=> $stable(target) && $stable(step_inc))
    else $error("instruction taken while busy");

  AST_STATUS_BUSY: assert property (
    status_rd |=> !data_bus_oe_n && data_bus_out[7] == $past(busy_indicator))
    else $error("busy bit wrong on status read");

  AST_STATUS_AC: assert property (
    status_rd |=> data_bus_out[6:0] == $past(address_counter))
    else $error("counter wrong on status read");

  AST_ADDR_LOAD: assert property (
    addr_set && is_disp_set
    |=> address_counter == $past(data_bus_in[6:0]) && target == lhr_pkg::LHR_TGT_DISPLAY)
    else $error("address set not loaded");

  AST_PREFETCH: assert property (
    addr_set |=> mem_re ##1 state == lhr_pkg::LHR_ST_LOAD ##1 !busy_indicator)
    else $error("prefetch sequence wrong");

  AST_WRITE_MEM: assert property (
    data_wr |=> mem_we && mem_addr == {$past(target), $past(address_counter)}
    && data_register == $past(data_bus_in))
    else $error("data write not stored");

  AST_WRITE_STEP: assert property (
    data_wr |=> ##1 address_counter == lhr_pkg::lhr_step($past(address_counter, 2),
    $past(step_inc, 2)) && !busy_indicator)
    else $error("counter not stepped after write");

  AST_READ_DATA: assert property (
    data_rd |=> !data_bus_oe_n && data_bus_out == $past(data_register))
    else $error("data read wrong");

  AST_READ_REFETCH: assert property (
    data_rd |=> mem_re && address_counter == lhr_pkg::lhr_step($past(address_counter),
    $past(step_inc)) ##2 !busy_indicator)
    else $error("no refetch after read");

  AST_MODE_DIR: assert property (
    instr_wr && is_mode |=> step_inc == $past(data_bus_in[1]))
    else $error("direction not stored");

  // a data read that lands while busy must not drive the bus
  AST_BUSY_READ_IGNORED: assert property (
    access_strobe && busy_indicator && register_select && read_write |=> data_bus_oe_n)
    else $error("data read taken while busy");

  // an instruction write never opens a read path
  AST_INSTR_HIDDEN: assert property (
    access_strobe && !register_select && !read_write |=> data_bus_oe_n)
    else $error("instruction register driven out");

  // glyph and icon address set: 5-bit address, non-display target
  AST_SUB_ADDR_LOAD: assert property (
    addr_set && !is_disp_set
    |=> address_counter == {2'h0, $past(data_bus_in[4:0])}
    && target != lhr_pkg::LHR_TGT_DISPLAY)
    else $error("sub memory address set not loaded");

  COV_STATUS: cover property (status_rd && busy_indicator);
  COV_WRITE: cover property (data_wr ##3 data_wr);
  COV_READ: cover property (addr_set ##3 data_rd ##3 data_rd);
  COV_DECREMENT: cover property (!step_inc && data_rd);
endmodule : lhr_host_port
`default_nettype wire

// ==== lhr_host_model.sv ====
// host microprocessor model for the lcd host register port
// assumes ref_clk is the bench clock and strobes last one cycle
`timescale 1ns/10ps
`default_nettype none
module lhr_host_model (
  input wire logic ref_clk,
  input wire logic busy_indicator,
  output logic access_strobe,
  output logic register_select,
  output logic read_write,
  output logic [7:0] data_bus_in
);
  // idle bus levels at time zero
  initial begin
    access_strobe = 1'b0;
    register_select = 1'b0;
    read_write = 1'b1;
    data_bus_in = 8'h00;
  end

  // one strobed access, driven just after a rising edge
  task automatic access(input logic rs, input logic rw, input logic [7:0] d);
    @(posedge ref_clk);
    access_strobe <= 1'b1;
    register_select <= rs;
    read_write <= rw;
    data_bus_in <= d;
    @(posedge ref_clk);
    access_strobe <= 1'b0;
    data_bus_in <= ~d; // released bus shows no stale value
  endtask : access

  // hold off the next request until the device is idle; stuck flags a hang
  task automatic settle(output logic stuck);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (busy_indicator !== 1'b0 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    stuck = (busy_indicator !== 1'b0);
  endtask : settle
endmodule : lhr_host_model
`default_nettype wire

// ==== lhr_host_register_access_test.sv ====
// self-checking bench for the lcd host register port
// assumes the host model drives the port; reads are checked in order
`timescale 1ns/10ps
`default_nettype none
module lhr_host_register_access_test;
  logic ref_clk = 1'b0; // 25 MHz clock
  logic arst_n = 1'b0; // reset, active low
  logic access_strobe, register_select, read_write;
  logic busy_indicator, data_bus_oe_n;
  logic [7:0] data_bus_in, data_bus_out;
  logic [7:0] exp_q[$]; // expected read values, oldest first
  logic [7:0] d0, d1, g, ic; // payloads: d0 and g random, d1 and ic their complements
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  // clock generator
  always #20 ref_clk = ~ref_clk;

  lhr_host_model lhr_host_model_i (.ref_clk(ref_clk), .busy_indicator(busy_indicator),
    .access_strobe(access_strobe), .register_select(register_select),
    .read_write(read_write), .data_bus_in(data_bus_in));

  lhr_host_port lhr_host_port_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .access_strobe(access_strobe), .register_select(register_select),
    .read_write(read_write), .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
    .data_bus_oe_n(data_bus_oe_n), .busy_indicator(busy_indicator));

  // compare one read value
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // verdict and end of run
  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // note an expected read, then issue it
  task automatic rd(input logic rs, input logic [7:0] exp);
    exp_q.push_back(exp);
    lhr_host_model_i.access(rs, 1'b1, 8'h00);
  endtask : rd

  // plain write access
  task automatic wr(input logic rs, input logic [7:0] d);
    lhr_host_model_i.access(rs, 1'b0, d);
  endtask : wr

  // wait until idle; a busy indicator that never drops is a mismatch
  task automatic idle();
    logic stuck;
    lhr_host_model_i.settle(stuck);
    chk("busy release", 8'h00, {7'h00, stuck});
  endtask : idle

  // watcher: each bus drive takes the oldest note
  always @(posedge ref_clk) begin
    if (arst_n === 1'b1 && data_bus_oe_n === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("unexpected drive", 8'h00, 8'hFF);
      end else begin
        chk("read data", exp_q.pop_front(), data_bus_out);
      end
    end
  end

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    void'($urandom(14641));
    d0 = 8'($urandom());
    d1 = ~d0;
    g = 8'($urandom());
    ic = ~g;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(1'b0, 8'h00);
    idle();
    wr(1'b0, 8'h85);
    idle();
    wr(1'b1, d0);
    idle();
    wr(1'b1, d1);
    idle();
    rd(1'b0, 8'h07);
    idle();
    wr(1'b0, 8'h85);
    rd(1'b0, 8'h85);
    idle();
    wr(1'b0, 8'h85);
    wr(1'b1, ~d0);
    rd(1'b0, 8'h05);
    idle();
    wr(1'b0, 8'h85);
    wr(1'b0, 8'h43);
    rd(1'b0, 8'h05);
    idle();
    wr(1'b0, 8'h85);
    lhr_host_model_i.access(1'b1, 1'b1, 8'h00);
    rd(1'b0, 8'h05);
    idle();
    rd(1'b1, d0);
    idle();
    rd(1'b1, d1);
    idle();
    wr(1'b0, 8'h04);
    idle();
    wr(1'b0, 8'h86);
    idle();
    rd(1'b1, d1);
    idle();
    rd(1'b1, d0);
    idle();
    rd(1'b0, 8'h04);
    idle();
    wr(1'b0, 8'h06);
    idle();
    wr(1'b0, 8'h43);
    idle();
    wr(1'b1, g);
    idle();
    wr(1'b0, 8'h23);
    idle();
    wr(1'b1, ic);
    idle();
    wr(1'b0, 8'h43);
    idle();
    rd(1'b1, g);
    idle();
    wr(1'b0, 8'h23);
    idle();
    rd(1'b1, ic);
    idle();
    rd(1'b0, 8'h04);
    idle();
    wr(1'b0, 8'h01);
    rd(1'b0, 8'h04);
    idle();
    wr(1'b0, 8'h04);
    idle();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(1'b0, 8'h00);
    idle();
    wr(1'b1, d1);
    idle();
    rd(1'b0, 8'h01);
    idle();
    repeat (3) @(posedge ref_clk);
    chk("pending reads", 8'h00, 8'(exp_q.size()));
    wrap_up();
  end
endmodule : lhr_host_register_access_test
`default_nettype wire
